// ===== design/timer_ch0_io_function_select.sv
// module: channel 0 pin function select for general registers a and c, with apb registers
//
// Functional notes
// (R01) Top bit clear: output compare; bit 2 is initial level; 01 drives low on match.
// (R02) Compare mode with low bits 10 drives the pin high on each match.
// (R03) Low bits 11 toggle on each match; 00 disables the output regardless of bit 2.
// (R04) Top bit set, bits 2..0 zero: capture the count on a rising pin edge.
// (R05) Top bit set, bits 2..0 001: capture the count on a falling pin edge.
// (R06) Top bit set, bit 2 clear, bit 1 set: capture on both pin edges.
// (R07) Top bit and bit 2 set: capture whenever the channel 1 counter counts.
// (R08) The c field decodes like the a field, for register c and its pin.
// (R09) No channel 1 count capture while its prescaler select is 000.
// (R10) Buffer mode a: register c buffers a, and its own field does nothing.
// (R11) Disabled output or capture roles leave the pin undriven by the timer.
module timer_ch0_io_function_select #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input logic clock,
    input logic reset_n,
    // apb slave
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // counters
    input logic [CNT_W-1:0] counter_ch0,
    input logic [CNT_W-1:0] counter_ch1,
    // pin a
    input logic timer_pin_a_ch0_in,
    output logic timer_pin_a_ch0_out,
    output logic timer_pin_a_ch0_oe,
    // pin c
    input logic timer_pin_c_ch0_in,
    output logic timer_pin_c_ch0_out,
    output logic timer_pin_c_ch0_oe
);
    typedef struct packed {
        logic [7:0] io_high;
        logic [7:0] io_low;
        logic [7:0] mode_ch0;
        logic [7:0] ctrl_ch1;
        logic [CNT_W-1:0] greg_a;
        logic [CNT_W-1:0] greg_c;
        logic [3:0] flags;
        logic [31:0] rdata;
    } top_state_t;
    top_state_t st_r, st_nxt;

    logic [3:0] func_a;
    logic [3:0] func_c;
    logic [2:0] psc_ch1;
    logic buf_mode;
    logic cnt_event;
    logic cap_a;
    logic cmp_a;
    logic cap_c;
    logic cmp_c;
    logic mapped;
    logic setup_ph;
    logic wr_acc;
    logic [31:0] rd_mux;
    logic [3:0] flag_set;
    logic [3:0] flag_clr;

    // fields pulled from the control registers
    assign func_a = st_r.io_high[tmr_io_pkg::FUNC_LSB +: tmr_io_pkg::FUNC_W];
    assign func_c = st_r.io_low[tmr_io_pkg::FUNC_LSB +: tmr_io_pkg::FUNC_W];
    assign psc_ch1 = st_r.ctrl_ch1[tmr_io_pkg::PSC_LSB +: tmr_io_pkg::PSC_W];
    assign buf_mode = st_r.mode_ch0[tmr_io_pkg::BUF_A_BIT];

    // channel 1 count events, shared by both fields
    count_change_detect #(
        .WIDTH(CNT_W)
    ) u_count_det (
        .clock(clock),
        .reset_n(reset_n),
        .count(counter_ch1),
        .prescaler_sel(psc_ch1),
        .count_event(cnt_event)
    );

    // register a role and pin
    io_func_channel u_chan_a (
        .clock(clock),
        .reset_n(reset_n),
        .func(func_a),
        .inhibit(1'b0),
        .match_level(counter_ch0 == st_r.greg_a),
        .pin_in(timer_pin_a_ch0_in),
        .count_event(cnt_event),
        .pin_out(timer_pin_a_ch0_out),
        .pin_oe(timer_pin_a_ch0_oe),
        .capture(cap_a),
        .compare(cmp_a)
    );

    // register c role and pin, silenced while it buffers register a
    io_func_channel u_chan_c (
        .clock(clock),
        .reset_n(reset_n),
        .func(func_c),
        .inhibit(buf_mode),
        .match_level(counter_ch0 == st_r.greg_c),
        .pin_in(timer_pin_c_ch0_in),
        .count_event(cnt_event),
        .pin_out(timer_pin_c_ch0_out),
        .pin_oe(timer_pin_c_ch0_oe),
        .capture(cap_c),
        .compare(cmp_c)
    ); // R08 R10

    // apb decode: zero wait state, data latched during the setup cycle
    assign setup_ph = psel && !penable;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;
    assign wr_acc = psel && penable && pwrite && mapped;
    assign prdata = st_r.rdata;

    // read mux and address map
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            tmr_io_pkg::OFS_IO_HIGH: rd_mux[7:0] = st_r.io_high;
            tmr_io_pkg::OFS_IO_LOW: rd_mux[7:0] = st_r.io_low;
            tmr_io_pkg::OFS_MODE_CH0: rd_mux[7:0] = st_r.mode_ch0;
            tmr_io_pkg::OFS_CTRL_CH1: rd_mux[7:0] = st_r.ctrl_ch1;
            tmr_io_pkg::OFS_GREG_A: rd_mux[CNT_W-1:0] = st_r.greg_a;
            tmr_io_pkg::OFS_GREG_C: rd_mux[CNT_W-1:0] = st_r.greg_c;
            tmr_io_pkg::OFS_STATUS: begin
                rd_mux[3:0] = st_r.flags;
                rd_mux[tmr_io_pkg::ST_PIN_A] = timer_pin_a_ch0_out;
                rd_mux[tmr_io_pkg::ST_PIN_C] = timer_pin_c_ch0_out;
                rd_mux[tmr_io_pkg::ST_OE_A] = timer_pin_a_ch0_oe;
                rd_mux[tmr_io_pkg::ST_OE_C] = timer_pin_c_ch0_oe;
            end
            default: mapped = 1'b0;
        endcase
    end

    // sticky event flags: hardware set wins over a write-one clear in the same cycle
    always_comb begin
        flag_set = 4'h0;
        flag_set[tmr_io_pkg::ST_CAPT_A] = cap_a;
        flag_set[tmr_io_pkg::ST_CMP_A] = cmp_a;
        flag_set[tmr_io_pkg::ST_CAPT_C] = cap_c;
        flag_set[tmr_io_pkg::ST_CMP_C] = cmp_c;
        flag_clr = 4'h0;
        if (wr_acc && paddr == tmr_io_pkg::OFS_STATUS) begin
            flag_clr = pwdata[3:0];
        end
    end

    // next state: register writes, then captures and buffer moves which take priority
    always_comb begin
        st_nxt = st_r;
        st_nxt.flags = (st_r.flags & ~flag_clr) | flag_set;
        if (setup_ph) begin
            st_nxt.rdata = rd_mux;
        end
        if (wr_acc) begin
            case (paddr)
                tmr_io_pkg::OFS_IO_HIGH: st_nxt.io_high = pwdata[7:0];
                tmr_io_pkg::OFS_IO_LOW: st_nxt.io_low = pwdata[7:0];
                tmr_io_pkg::OFS_MODE_CH0: st_nxt.mode_ch0 = pwdata[7:0];
                tmr_io_pkg::OFS_CTRL_CH1: st_nxt.ctrl_ch1 = pwdata[7:0];
                tmr_io_pkg::OFS_GREG_A: st_nxt.greg_a = pwdata[CNT_W-1:0];
                tmr_io_pkg::OFS_GREG_C: st_nxt.greg_c = pwdata[CNT_W-1:0];
                default: st_nxt.rdata = st_nxt.rdata;
            endcase
        end
        // register a: capture latches the count; in buffer mode the old value moves to c
        if (cap_a) begin
            st_nxt.greg_a = counter_ch0; // R04
            if (buf_mode) begin
                st_nxt.greg_c = st_r.greg_a; // R10
            end
        end else if (cmp_a && buf_mode) begin
            // buffered compare: the next compare value is taken from c
            st_nxt.greg_a = st_r.greg_c; // R10
        end
        // register c captures only when it is not acting as a buffer
        if (cap_c) begin
            st_nxt.greg_c = counter_ch0; // R08
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_r.io_high <= tmr_io_pkg::IO_CTRL_RST;
            st_r.io_low <= tmr_io_pkg::IO_CTRL_RST;
            st_r.mode_ch0 <= tmr_io_pkg::MODE_RST;
            st_r.ctrl_ch1 <= tmr_io_pkg::CTRL1_RST;
            st_r.greg_a <= tmr_io_pkg::GREG_RST;
            st_r.greg_c <= tmr_io_pkg::GREG_RST;
            st_r.flags <= 4'h0;
            st_r.rdata <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    // checks: compare actions on pin a
    sequence s_cmp_a_low;
        (cmp_a && func_a[1:0] == 2'h1) ##1 $stable(func_a);
    endsequence

    sequence s_cmp_a_high;
        (cmp_a && func_a[1:0] == 2'h2) ##1 $stable(func_a);
    endsequence

    sequence s_cmp_a_toggle;
        (cmp_a && func_a[1:0] == 2'h3) ##1 $stable(func_a);
    endsequence

    a_match_drives_low: assert property (@(posedge clock) disable iff (!reset_n) // R01
        s_cmp_a_low |-> !timer_pin_a_ch0_out)
        else $error("pin a not low after compare match");

    a_match_drives_high: assert property (@(posedge clock) disable iff (!reset_n) // R02
        s_cmp_a_high |-> timer_pin_a_ch0_out)
        else $error("pin a not high after compare match");

    a_match_toggles: assert property (@(posedge clock) disable iff (!reset_n) // R03
        s_cmp_a_toggle |-> timer_pin_a_ch0_out != $past(timer_pin_a_ch0_out))
        else $error("pin a did not toggle on compare match");

    a_initial_level: assert property (@(posedge clock) disable iff (!reset_n) // R01
        (wr_acc && paddr == tmr_io_pkg::OFS_IO_HIGH && !pwdata[3] && pwdata[3:0] != func_a)
        ##1 !cmp_a |=> timer_pin_a_ch0_out == $past(func_a[2]))
        else $error("pin a initial level wrong");

    a_disabled_undriven: assert property (@(posedge clock) disable iff (!reset_n) // R03
        (!func_a[3] && func_a[1:0] == 2'h0) |-> !timer_pin_a_ch0_oe)
        else $error("pin a driven while output disabled");

    // checks: capture sources
    a_rise_capture: assert property (@(posedge clock) disable iff (!reset_n) // R04
        (func_a == 4'h8 && timer_pin_a_ch0_in && !$past(timer_pin_a_ch0_in)) |-> cap_a)
        else $error("rising edge not captured on a");

    a_fall_capture: assert property (@(posedge clock) disable iff (!reset_n) // R05
        (func_a == 4'h9 && !timer_pin_a_ch0_in && $past(timer_pin_a_ch0_in)) |-> cap_a)
        else $error("falling edge not captured on a");

    a_both_capture: assert property (@(posedge clock) disable iff (!reset_n) // R06
        (func_a[3:1] == 3'h5 && $past(reset_n)) |-> cap_a == (timer_pin_a_ch0_in != $past(timer_pin_a_ch0_in)))
        else $error("both edge capture wrong on a");

    a_count_capture: assert property (@(posedge clock) disable iff (!reset_n) // R07
        (func_a[3:2] == 2'h3) |-> cap_a == cnt_event)
        else $error("count capture wrong on a");

    a_undivided_none: assert property (@(posedge clock) disable iff (!reset_n) // R09
        (psc_ch1 == tmr_io_pkg::PSC_UNDIVIDED) |-> !cnt_event)
        else $error("count event with undivided clock");

    a_capture_loads: assert property (@(posedge clock) disable iff (!reset_n) // R04
        cap_a |=> st_r.greg_a == $past(counter_ch0))
        else $error("register a did not take the count");

    a_c_capture_loads: assert property (@(posedge clock) disable iff (!reset_n) // R08
        (cap_c && !cap_a) |=> st_r.greg_c == $past(counter_ch0))
        else $error("register c did not take the count");

    a_c_rise_capture: assert property (@(posedge clock) disable iff (!reset_n) // R08
        (!buf_mode && func_c == 4'h8 && timer_pin_c_ch0_in && !$past(timer_pin_c_ch0_in)) |-> cap_c)
        else $error("rising edge not captured on c");

    a_buffer_silences_c: assert property (@(posedge clock) disable iff (!reset_n) // R10
        buf_mode |-> !cap_c && !cmp_c && !timer_pin_c_ch0_oe)
        else $error("register c active while buffering");

    a_capture_undriven: assert property (@(posedge clock) disable iff (!reset_n) // R11
        (func_a[3] || func_c[3]) |-> !(func_a[3] && timer_pin_a_ch0_oe) && !(func_c[3] && timer_pin_c_ch0_oe))
        else $error("pin driven in capture role");

    a_flag_set_wins: assert property (@(posedge clock) disable iff (!reset_n)
        cap_a |=> st_r.flags[tmr_io_pkg::ST_CAPT_A])
        else $error("capture flag lost");
endmodule : timer_ch0_io_function_select

// ===== design/tmr_io_pkg.sv
// package: register map, field layout, reset values and pin function decode for channel 0
package tmr_io_pkg;
    // register byte offsets on the apb port
    localparam logic [7:0] OFS_IO_HIGH = 8'h00;
    localparam logic [7:0] OFS_IO_LOW = 8'h04;
    localparam logic [7:0] OFS_MODE_CH0 = 8'h08;
    localparam logic [7:0] OFS_CTRL_CH1 = 8'h0C;
    localparam logic [7:0] OFS_GREG_A = 8'h10;
    localparam logic [7:0] OFS_GREG_C = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    // field positions
    localparam int FUNC_LSB = 0;
    localparam int FUNC_W = 4;
    localparam int BUF_A_BIT = 0;
    localparam int PSC_LSB = 0;
    localparam int PSC_W = 3;
    localparam int ST_CAPT_A = 0;
    localparam int ST_CMP_A = 1;
    localparam int ST_CAPT_C = 2;
    localparam int ST_CMP_C = 3;
    localparam int ST_PIN_A = 8;
    localparam int ST_PIN_C = 9;
    localparam int ST_OE_A = 10;
    localparam int ST_OE_C = 11;
    // reset values
    localparam logic [7:0] IO_CTRL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [15:0] GREG_RST = 16'hFFFF;
    localparam logic [2:0] PSC_UNDIVIDED = 3'h0;

    // role of a general register and its pin
    typedef enum logic [2:0] {
        MODE_OFF = 3'h0,
        OC_LOW = 3'h1,
        OC_HIGH = 3'h3,
        OC_TOGGLE = 3'h2,
        IC_RISE = 3'h6,
        IC_FALL = 3'h7,
        IC_BOTH = 3'h5,
        IC_COUNT = 3'h4
    } pin_mode_t;

    // turns a four bit function field into a role
    function automatic pin_mode_t decode_func(input logic [3:0] func);
        pin_mode_t m;
        m = MODE_OFF;
        if (!func[3]) begin
            case (func[1:0])
                2'h1: m = OC_LOW;
                2'h2: m = OC_HIGH;
                2'h3: m = OC_TOGGLE;
                default: m = MODE_OFF;
            endcase
        end else if (func[2]) begin
            m = IC_COUNT;
        end else if (func[1]) begin
            m = IC_BOTH;
        end else if (func[0]) begin
            m = IC_FALL;
        end else begin
            m = IC_RISE;
        end
        return m;
    endfunction : decode_func
endpackage : tmr_io_pkg

// ===== design/count_change_detect.sv
// module: flags every change of the channel 1 count as a count event, except while the prescaler select is 000
module count_change_detect #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input logic clock,
    input logic reset_n,
    // counter watch
    input logic [WIDTH-1:0] count,
    input logic [2:0] prescaler_sel,
    output logic count_event
);
    typedef struct packed {
        logic [WIDTH-1:0] prev;
        logic primed;
    } det_state_t;
    det_state_t st_r, st_nxt;

    // the first sample after reset only primes the history, so no false event
    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = count;
        st_nxt.primed = 1'b1;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // an undivided count clock gives no event at all
    assign count_event = st_r.primed && (count != st_r.prev)
        && (prescaler_sel != tmr_io_pkg::PSC_UNDIVIDED); // R09
endmodule : count_change_detect

// ===== design/io_func_channel.sv
// module: one general register role decoder with its pin driver and capture edge detect
module io_func_channel (
    // clock and reset
    input logic clock,
    input logic reset_n,
    // setting
    input logic [3:0] func,
    input logic inhibit,
    // event sources
    input logic match_level,
    input logic pin_in,
    input logic count_event,
    // results
    output logic pin_out,
    output logic pin_oe,
    output logic capture,
    output logic compare
);
    typedef struct packed {
        logic pin;
        logic pin_prev;
        logic match_prev;
        logic [3:0] func_prev;
    } ch_state_t;
    ch_state_t st_r, st_nxt;
    tmr_io_pkg::pin_mode_t mode;
    logic rise;
    logic fall;

    assign mode = tmr_io_pkg::decode_func(func);
    assign rise = pin_in && !st_r.pin_prev;
    assign fall = !pin_in && st_r.pin_prev;
    // a match is one event per arrival of the count, not per cycle it stays equal
    assign compare = !inhibit && !func[3] && match_level && !st_r.match_prev;

    // capture source picked by the role
    always_comb begin
        capture = 1'b0;
        if (!inhibit) begin
            case (mode)
                tmr_io_pkg::IC_RISE: capture = rise; // R04
                tmr_io_pkg::IC_FALL: capture = fall; // R05
                tmr_io_pkg::IC_BOTH: capture = rise || fall; // R06
                tmr_io_pkg::IC_COUNT: capture = count_event; // R07
                default: capture = 1'b0;
            endcase
        end
    end

    // pin level: initial level on entering compare mode, then the match action
    always_comb begin
        st_nxt = st_r;
        st_nxt.pin_prev = pin_in;
        st_nxt.match_prev = match_level;
        if (!inhibit) begin
            st_nxt.func_prev = func;
            if (!func[3] && func != st_r.func_prev) begin
                st_nxt.pin = func[2]; // R01
            end else if (compare) begin
                case (func[1:0])
                    2'h1: st_nxt.pin = 1'b0; // R01
                    2'h2: st_nxt.pin = 1'b1; // R02
                    2'h3: st_nxt.pin = !st_r.pin; // R03
                    default: st_nxt.pin = st_r.pin;
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_out = st_r.pin;
    // disabled output and capture roles leave the pin to the outside
    assign pin_oe = !inhibit && !func[3] && (func[1:0] != 2'h0); // R03 R11
endmodule : io_func_channel

// ===== verification/pin_partner.sv
// pin partner: the outside world on the two channel 0 timer pins
module pin_partner (
    // what the block drives
    input wire logic out_a,
    input wire logic oe_a,
    input wire logic out_c,
    input wire logic oe_c,
    // levels the outside source wants when the block lets go
    input wire logic lvl_a,
    input wire logic lvl_c,
    // resolved pin levels
    output wire logic pin_a,
    output wire logic pin_c
);
    timeunit 1ns;
    timeprecision 1ps;
    // the source backs off while the block drives, so no contention is modelled
    assign pin_a = oe_a ? out_a : lvl_a;
    assign pin_c = oe_c ? out_c : lvl_c;
endmodule : pin_partner

// ===== verification/timer_ch0_io_function_select_tb_top.sv
// testbench: apb driven checks of the channel 0 pin function decode
module timer_ch0_io_function_select_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic rd;
        logic err;
        logic [31:0] exp;
        logic [31:0] mask;
    } note_t;
    logic clock, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] counter_ch0, counter_ch1;
    logic pin_a, pin_c, lvl_a, lvl_c, out_a, oe_a, out_c, oe_c;
    note_t notes[$];
    note_t n;
    int err_count, comparisons;

    timer_ch0_io_function_select #(.CNT_W(16)) dut (
        .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .counter_ch0(counter_ch0), .counter_ch1(counter_ch1),
        .timer_pin_a_ch0_in(pin_a), .timer_pin_a_ch0_out(out_a), .timer_pin_a_ch0_oe(oe_a),
        .timer_pin_c_ch0_in(pin_c), .timer_pin_c_ch0_out(out_c), .timer_pin_c_ch0_oe(oe_c)
    );

    pin_partner partner (
        .out_a(out_a), .oe_a(oe_a), .out_c(out_c), .oe_c(oe_c),
        .lvl_a(lvl_a), .lvl_c(lvl_c), .pin_a(pin_a), .pin_c(pin_c)
    );

    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // watcher: oldest note against each finished transfer
    always @(posedge clock) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && notes.size() > 0) begin
            n = notes.pop_front();
            comparisons++;
            if (pslverr !== n.err || (n.rd && (prdata & n.mask) !== n.exp)) begin
                err_count++;
                $display("wrong value at %0t: got %h %h expected %h %h",
                         $time, pslverr, prdata & n.mask, n.err, n.exp);
            end
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0 && notes.size() == 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    // one apb transfer; anything past the status word is unmapped
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
                        input logic [31:0] m);
        int w;
        w = 0;
        notes.push_back('{rd: !wr, err: (a > tmr_io_pkg::OFS_STATUS), exp: e & m, mask: m});
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            w++;
        end while (pready !== 1'b1 && w < 50);
        if (w >= 50) begin
            err_count++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 32'h0, 32'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        xfer(1'b0, a, 32'h0, e, m);
    endtask : rd

    // status word of one channel: capture, compare, pin level, drive enable
    function automatic logic [31:0] stat(input int ch, input logic cp, input logic cm, input logic p, input logic oe);
        logic [31:0] s;
        s = 32'h0;
        s[tmr_io_pkg::ST_CAPT_A + 2 * ch] = cp;
        s[tmr_io_pkg::ST_CMP_A + 2 * ch] = cm;
        s[tmr_io_pkg::ST_PIN_A + ch] = p;
        s[tmr_io_pkg::ST_OE_A + ch] = oe;
        return s;
    endfunction : stat

    // outside level change, then time for the edge to land
    task automatic drive_pin(input int ch, input logic v);
        @(posedge clock);
        if (ch == 0) begin
            lvl_a <= v;
        end else begin
            lvl_c <= v;
        end
        repeat (3) @(posedge clock);
    endtask : drive_pin

    // compare role: initial level, then the action at a match
    task automatic cmp_test(input int ch, input logic [3:0] f);
        logic [15:0] v;
        logic lvl, on;
        v = 16'($urandom());
        on = (f[1:0] != 2'h0);
        lvl = (f[1:0] == 2'h1) ? 1'b0 : (f[1:0] == 2'h2) ? 1'b1 : ~f[2];
        counter_ch0 <= v ^ 16'h5A5A;
        wr(ch ? tmr_io_pkg::OFS_GREG_C : tmr_io_pkg::OFS_GREG_A, {16'hFFFF, v});
        wr(ch ? tmr_io_pkg::OFS_IO_LOW : tmr_io_pkg::OFS_IO_HIGH, {28'hFFFFFFF, f});
        // the register keeps all eight written bits, so the upper nibble reads back as written
        rd(ch ? tmr_io_pkg::OFS_IO_LOW : tmr_io_pkg::OFS_IO_HIGH, {24'h0, 4'hF, f}, 32'hFFFFFFFF);
        wr(tmr_io_pkg::OFS_STATUS, 32'hF);
        rd(tmr_io_pkg::OFS_STATUS, stat(ch, 0, 0, f[2], on), stat(ch, 1, 1, on, 1));
        counter_ch0 <= v;
        repeat (3) @(posedge clock);
        rd(tmr_io_pkg::OFS_STATUS, stat(ch, 0, 1, lvl, on), stat(ch, 1, 1, on, 1));
    endtask : cmp_test

    // capture role: rising edge, falling edge, then a channel 1 count step
    task automatic cap_test(input int ch, input logic [3:0] f, input logic up, input logic dn, input logic cn);
        logic [15:0] c, g;
        logic [7:0] ga;
        c = 16'($urandom());
        g = c ^ 16'h00FF;
        ga = ch ? tmr_io_pkg::OFS_GREG_C : tmr_io_pkg::OFS_GREG_A;
        counter_ch0 <= c;
        drive_pin(ch, 1'b0);
        wr(ch ? tmr_io_pkg::OFS_IO_LOW : tmr_io_pkg::OFS_IO_HIGH, {28'h0, f});
        for (int k = 0; k < 3; k++) begin
            wr(ga, {16'h0, g});
            wr(tmr_io_pkg::OFS_STATUS, 32'hF);
            if (k < 2) begin
                drive_pin(ch, k == 0);
            end else begin
                counter_ch1 <= counter_ch1 + 16'h1;
                repeat (3) @(posedge clock);
            end
            rd(ga, ((k == 0 && up) || (k == 1 && dn) || (k == 2 && cn)) ? c : g, 32'hFFFF);
            rd(tmr_io_pkg::OFS_STATUS, stat(ch, (k == 0 && up) || (k == 1 && dn) || (k == 2 && cn), 0, 0, 0),
               stat(ch, 1, 0, 0, 1));
        end
    endtask : cap_test

    // main sequence
    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        counter_ch0 = 16'h0;
        counter_ch1 = 16'h0;
        lvl_a = 1'b0;
        lvl_c = 1'b0;
        err_count = 0;
        comparisons = 0;
        void'($urandom(47));
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        // reset values and an unmapped place
        rd(tmr_io_pkg::OFS_IO_HIGH, {24'h0, tmr_io_pkg::IO_CTRL_RST}, 32'hFFFFFFFF);
        rd(tmr_io_pkg::OFS_IO_LOW, {24'h0, tmr_io_pkg::IO_CTRL_RST}, 32'hFFFFFFFF);
        rd(tmr_io_pkg::OFS_GREG_A, {16'h0, tmr_io_pkg::GREG_RST}, 32'hFFFFFFFF);
        rd(tmr_io_pkg::OFS_STATUS, 32'h0, 32'hFFFFFFFF);
        wr(8'h1C, 32'hFFFFFFFF);
        rd(8'h1C, 32'h0, 32'hFFFFFFFF);
        // every code on both fields, with a divided channel 1 clock
        wr(tmr_io_pkg::OFS_CTRL_CH1, 32'h1);
        for (int ch = 0; ch < 2; ch++) begin
            for (int f = 0; f < 16; f++) begin
                if (f < 8) begin
                    cmp_test(ch, 4'(f));
                end else begin
                    cap_test(ch, 4'(f), f < 12 && (f[1] || !f[0]), f < 12 && (f[1] || f[0]), f >= 12);
                end
            end
        end
        // undivided channel 1 clock gives no count capture
        wr(tmr_io_pkg::OFS_CTRL_CH1, 32'h0);
        cap_test(0, 4'hC, 1'b0, 1'b0, 1'b0);
        // buffer mode: the c field has no say over pin c
        wr(tmr_io_pkg::OFS_MODE_CH0, 32'h1);
        wr(tmr_io_pkg::OFS_IO_LOW, 32'h5);
        rd(tmr_io_pkg::OFS_STATUS, 32'h0, stat(1, 0, 0, 0, 1));
        wr(tmr_io_pkg::OFS_IO_LOW, 32'h8);
        wr(tmr_io_pkg::OFS_STATUS, 32'hF);
        drive_pin(1, 1'b1);
        rd(tmr_io_pkg::OFS_STATUS, 32'h0, stat(1, 1, 0, 0, 1));
        @(posedge clock);
        give_verdict();
    end

    // watchdog, well past the roughly 1300 cycles the tests take
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        give_verdict();
    end
endmodule : timer_ch0_io_function_select_tb_top
